/* cam_core.sv */
// address mode decoder with flag unit behind an axi4-lite register slave
`timescale 1ns/10ps
`include "cam_defines.svh"

// Overview of operation
// - ten addressing modes are decoded, with lengths from one to three bytes.
// - no-operand opcodes are one byte long and fetch nothing after the opcode.
// - literal operand mode gives address pc+1 and advances pc by two.
// - direct mode gives high byte zero and low byte the next byte, pc plus two.
// - full address mode joins the two next bytes high then low, pc plus three.
// - half carry takes the carry out of bit 3 for arithmetic that affects it.
// - the flag register holds negative, zero, carry, interrupt mask and half carry.
// - each flag an opcode defines is set if its condition holds, else cleared; others keep.
// - index no-offset mode addresses the index register with high byte zero, pc plus one.
// - index byte offset adds index and next byte, carry into high byte, pc plus two.
// - index word offset adds index to the next two bytes with carry, pc plus three.
// - a branch goes to pc+2 plus the signed offset when taken, else to pc+2.
module cam_core (
    input  wire logic        clk,      // 40 mhz clock
    input  wire logic        rst_b,    // async reset, active low
    input  wire logic [7:0]  awaddr,   // write address
    input  wire logic        awvalid,  // write address valid
    output wire logic        awready,  // write address ready
    input  wire logic [31:0] wdata,    // write data
    input  wire logic [3:0]  wstrb,    // write byte strobes
    input  wire logic        wvalid,   // write data valid
    output wire logic        wready,   // write data ready
    output logic      [1:0]  bresp,    // write response
    output logic             bvalid,   // write response valid
    input  wire logic        bready,   // write response ready
    input  wire logic [7:0]  araddr,   // read address
    input  wire logic        arvalid,  // read address valid
    output wire logic        arready,  // read address ready
    output logic      [31:0] rdata,    // read data
    output logic      [1:0]  rresp,    // read response
    output logic             rvalid,   // read data valid
    input  wire logic        rready    // read data ready
);

    // ================================================================
    // state
    logic [7:0]  awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d, rdata_d;
    logic [3:0]  wstrb_q, wstrb_d;
    logic        aw_q, aw_d, w_q, w_d, bvalid_d, rvalid_d, start_q, start_d, done_q, done_d;
    logic [1:0]  bresp_d, rresp_d;
    logic [31:0] insn_q, insn_d, alu_q, alu_d;
    logic [15:0] pc_q, pc_d;
    logic [7:0]  index_q, index_d;
    logic        taken_q, taken_d, do_write;
    cam_pkg::cam_flags_t  flags_q, flags_d;
    cam_pkg::cam_result_t res_q, res_d, dec;

    // byte-lane merge, used by every writable register except control
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        merge = old;
        for (int k = 0; k < 4; k++) begin
            if (strb[k]) begin
                merge[8*k +: 8] = nw[8*k +: 8];
            end
        end
    endfunction : merge

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'h0) && (a <= `CAM_OFF_ALU);
    endfunction : mapped

    assign awready  = !aw_q;
    assign wready   = !w_q;
    assign arready  = !rvalid;
    assign do_write = aw_q && w_q && !bvalid;

    cam_decode u_decode (
        .opcode (insn_q[7:0]),
        .byte1  (insn_q[15:8]),
        .byte2  (insn_q[23:16]),
        .pc     (pc_q),
        .index  (index_q),
        .taken  (taken_q),
        .result (dec)
    );

    logic [7:0] op_a, op_b;
    logic [8:0] sum9;
    logic [4:0] half5;
    logic [7:0] res8;
    logic       cin;

    // ================================================================
    // bus slave: address and data taken in either order, response after both
    always_comb begin
        awaddr_d = awaddr_q;
        wdata_d  = wdata_q;
        wstrb_d  = wstrb_q;
        aw_d     = aw_q;
        w_d      = w_q;
        bvalid_d = bvalid;
        bresp_d  = bresp;
        rvalid_d = rvalid;
        rresp_d  = rresp;
        rdata_d  = rdata;
        if (awvalid && awready) begin
            aw_d     = 1'b1;
            awaddr_d = awaddr;
        end
        if (wvalid && wready) begin
            w_d     = 1'b1;
            wdata_d = wdata;
            wstrb_d = wstrb;
        end
        if (bvalid && bready) begin
            bvalid_d = 1'b0;
        end
        if (do_write) begin
            aw_d     = 1'b0;
            w_d      = 1'b0;
            bvalid_d = 1'b1;
            bresp_d  = mapped(awaddr_q) ? `CAM_RESP_OKAY : `CAM_RESP_DECERR;
        end
        if (rvalid && rready) begin
            rvalid_d = 1'b0;
        end
        // read data captured at the address handshake, answered one cycle later
        if (arvalid && arready) begin
            rvalid_d = 1'b1;
            rresp_d  = mapped(araddr) ? `CAM_RESP_OKAY : `CAM_RESP_DECERR;
            case (araddr)
                `CAM_OFF_CTRL:   rdata_d = {30'h0, taken_q, 1'b0};
                `CAM_OFF_INSN:   rdata_d = insn_q;
                `CAM_OFF_PC:     rdata_d = {16'h0, pc_q};
                `CAM_OFF_INDEX:  rdata_d = {24'h0, index_q};
                `CAM_OFF_RESULT: rdata_d = {res_q.next_pc, res_q.effective_address};
                `CAM_OFF_STATUS: rdata_d = {23'h0, done_q, 2'h0, res_q.length, res_q.mode};
                `CAM_OFF_FLAGS:  rdata_d = {27'h0, flags_q};
                `CAM_OFF_ALU:    rdata_d = alu_q;
                default:         rdata_d = `CAM_RST_WORD;
            endcase
        end
    end

    // ================================================================
    // operand arithmetic for flag updates; operation from the low nibble
    always_comb begin
        op_a  = (insn_q[3:0] == 4'h3) ? index_q : alu_q[7:0]; // compare index uses index
        op_b  = alu_q[15:8];
        cin   = ((insn_q[3:0] == 4'h2) || (insn_q[3:0] == 4'h9)) ? flags_q.c : 1'b0;
        sum9  = {1'b0, op_a} + {1'b0, op_b} + {8'h00, cin};
        half5 = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, cin};
        case (insn_q[3:0])
            4'h0, 4'h1, 4'h2, 4'h3: begin
                sum9 = {1'b0, op_a} - {1'b0, op_b} - {8'h00, cin}; // bit 8 is borrow
                res8 = sum9[7:0];
            end
            4'h4, 4'h5: res8 = op_a & op_b;
            4'h6:       res8 = op_b;
            4'h7:       res8 = op_a;
            4'h8:       res8 = op_a ^ op_b;
            4'ha:       res8 = op_a | op_b;
            default:    res8 = sum9[7:0];
        endcase
    end

    // ================================================================
    // register writes, decode capture and flag update
    always_comb begin
        insn_d  = insn_q;
        pc_d    = pc_q;
        index_d = index_q;
        alu_d   = alu_q;
        taken_d = taken_q;
        flags_d = flags_q;
        res_d   = res_q;
        start_d = 1'b0;
        done_d  = done_q;
        if (do_write) begin
            case (awaddr_q)
                `CAM_OFF_CTRL: begin
                    if (wstrb_q[0]) begin
                        taken_d = wdata_q[`CAM_CTRL_TAKEN];
                        start_d = wdata_q[`CAM_CTRL_START];
                        done_d  = 1'b0;
                    end
                end
                `CAM_OFF_INSN:  insn_d  = merge(insn_q, wdata_q, wstrb_q);
                `CAM_OFF_PC:    pc_d    = 16'(merge({16'h0, pc_q}, wdata_q, wstrb_q));
                `CAM_OFF_INDEX: index_d = 8'(merge({24'h0, index_q}, wdata_q, wstrb_q));
                `CAM_OFF_FLAGS: flags_d = 5'(merge({27'h0, flags_q}, wdata_q, wstrb_q));
                `CAM_OFF_ALU:   alu_d   = merge(alu_q, wdata_q, wstrb_q);
                default: ;
            endcase
        end
        // start runs one cycle after the control write so decode sees settled registers;
        // hardware flag update wins over a flag write in the same cycle
        if (start_q) begin
            res_d  = dec;
            done_d = 1'b1;
            if (insn_q[7:4] >= 4'ha) begin
                if (insn_q[3:0] <= 4'hb) begin
                    flags_d.n = res8[7];
                    flags_d.z = (res8 == 8'h00);
                end
                if ((insn_q[3:0] <= 4'h3) || (insn_q[3:0] == 4'h9) || (insn_q[3:0] == 4'hb))
                begin
                    flags_d.c = sum9[8]; // carry or borrow
                end
                if ((insn_q[3:0] == 4'h9) || (insn_q[3:0] == 4'hb)) begin
                    flags_d.h = half5[4]; // carry out of bit 3
                end
            end else if (insn_q[7:4] == 4'h9) begin
                case (insn_q[3:0])
                    4'h8:    flags_d.c = 1'b0;
                    4'h9:    flags_d.c = 1'b1;
                    4'ha:    flags_d.i = 1'b0;
                    4'hb:    flags_d.i = 1'b1;
                    default: ; // other control opcodes leave flags alone
                endcase
            end
        end
    end

    // ================================================================
    // registers only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            awaddr_q <= 8'h00;
            wdata_q  <= `CAM_RST_WORD;
            wstrb_q  <= 4'h0;
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            bvalid   <= 1'b0;
            bresp    <= `CAM_RESP_OKAY;
            rvalid   <= 1'b0;
            rresp    <= `CAM_RESP_OKAY;
            rdata    <= `CAM_RST_WORD;
            insn_q   <= `CAM_RST_WORD;
            pc_q     <= 16'h0000;
            index_q  <= 8'h00;
            alu_q    <= `CAM_RST_WORD;
            taken_q  <= 1'b0;
            flags_q  <= `CAM_RST_FLAGS;
            res_q    <= '0;
            start_q  <= 1'b0;
            done_q   <= 1'b0;
        end else begin
            awaddr_q <= awaddr_d;
            wdata_q  <= wdata_d;
            wstrb_q  <= wstrb_d;
            aw_q     <= aw_d;
            w_q      <= w_d;
            bvalid   <= bvalid_d;
            bresp    <= bresp_d;
            rvalid   <= rvalid_d;
            rresp    <= rresp_d;
            rdata    <= rdata_d;
            insn_q   <= insn_d;
            pc_q     <= pc_d;
            index_q  <= index_d;
            alu_q    <= alu_d;
            taken_q  <= taken_d;
            flags_q  <= flags_d;
            res_q    <= res_d;
            start_q  <= start_d;
            done_q   <= done_d;
        end
    end

    // ================================================================
    // checks on the captured decode and the flag update
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_len_range: assert property (done_q |-> res_q.length inside {2'h1, 2'h2, 2'h3})
        else $error("instruction length out of range");
    a_noop_len: assert property (start_q && dec.mode == cam_pkg::CAM_NO_OPERAND
        |=> res_q.length == 2'h1 && res_q.next_pc == $past(pc_q) + 16'h0001)
        else $error("no-operand length wrong");
    a_lit_addr: assert property (start_q && dec.mode == cam_pkg::CAM_LITERAL_OPERAND
        |=> res_q.effective_address == $past(pc_q) + 16'h0001
            && res_q.next_pc == $past(pc_q) + 16'h0002)
        else $error("literal operand address wrong");
    a_direct_page: assert property (start_q && dec.mode == cam_pkg::CAM_DIRECT
        |=> res_q.effective_address == {8'h00, $past(insn_q[15:8])}
            && res_q.next_pc == $past(pc_q) + 16'h0002)
        else $error("direct address wrong");
    a_full_addr: assert property (start_q && dec.mode == cam_pkg::CAM_FULL_ADDRESS
        |=> res_q.effective_address == {$past(insn_q[15:8]), $past(insn_q[23:16])}
            && res_q.length == 2'h3)
        else $error("full address wrong");
    a_half_carry: assert property (start_q && insn_q[7:4] >= 4'ha
        && insn_q[3:0] == 4'hb
        |=> flags_q.h == ({1'b0, $past(alu_q[3:0])} + {1'b0, $past(alu_q[11:8])} > 5'h0f))
        else $error("half carry wrong");
    a_flag_keep: assert property (start_q && insn_q[7:4] >= 4'ha && insn_q[3:0] >= 4'hc
        && !do_write |=> $stable(flags_q))
        else $error("unaffected flags changed");
    a_index_page: assert property (start_q && dec.mode == cam_pkg::CAM_INDEX_NO_OFFSET
        |=> res_q.effective_address == {8'h00, $past(index_q)})
        else $error("index no-offset address wrong");
    a_index_carry: assert property (start_q
        && dec.mode == cam_pkg::CAM_INDEX_BYTE_OFFSET
        |=> res_q.effective_address == {8'h00, $past(index_q)} + {8'h00, $past(insn_q[15:8])}
            && res_q.next_pc == $past(pc_q) + 16'h0002)
        else $error("index byte offset wrong");
    a_index_word: assert property (start_q
        && dec.mode == cam_pkg::CAM_INDEX_WORD_OFFSET
        |=> res_q.effective_address == $past(insn_q[15:8]) * 16'h0100
            + {8'h00, $past(insn_q[23:16])} + {8'h00, $past(index_q)})
        else $error("index word offset wrong");
    a_branch_skip: assert property (start_q && dec.mode == cam_pkg::CAM_BRANCH_OFFSET
        && !taken_q |=> res_q.next_pc == $past(pc_q) + 16'h0002
            && res_q.effective_address == $past(pc_q) + 16'h0002)
        else $error("untaken branch target wrong");
    a_nibble_mode: assert property (start_q && insn_q[7:4] == 4'hc
        |=> res_q.mode == cam_pkg::CAM_FULL_ADDRESS)
        else $error("upper nibble mode decode wrong");

    c_branch_taken: cover property (start_q && dec.mode == cam_pkg::CAM_BRANCH_OFFSET && taken_q);
    c_word_index:   cover property (start_q && dec.mode == cam_pkg::CAM_INDEX_WORD_OFFSET);
    c_write_read:   cover property (bvalid ##[1:8] rvalid);
    c_unmapped:     cover property (bvalid && bresp == `CAM_RESP_DECERR);

endmodule : cam_core

/* cam_decode.sv */
// combinational opcode decoder: mode, length, effective address, next pc
`timescale 1ns/10ps
`include "cam_defines.svh"

module cam_decode (
    input  wire logic [7:0]          opcode, // instruction opcode
    input  wire logic [7:0]          byte1,  // first byte after opcode
    input  wire logic [7:0]          byte2,  // second byte after opcode
    input  wire logic [15:0]         pc,     // address of the opcode
    input  wire logic [7:0]          index,  // index register
    input  wire logic                taken,  // branch condition true
    output cam_pkg::cam_result_t     result  // decode result
);

    // ================================================================
    // mode from the upper nibble of the opcode; for upper nibble a the low nibble d picks branch
    function automatic cam_pkg::cam_mode_t mode_of(input logic [7:0] op);
        case (op[7:4])
            4'h0:    mode_of = cam_pkg::CAM_BIT_TEST_BRANCH;
            4'h1:    mode_of = cam_pkg::CAM_BIT_SET_CLEAR;
            4'h2:    mode_of = cam_pkg::CAM_BRANCH_OFFSET;
            4'h3:    mode_of = cam_pkg::CAM_DIRECT;
            4'h6:    mode_of = cam_pkg::CAM_INDEX_BYTE_OFFSET;
            4'h7:    mode_of = cam_pkg::CAM_INDEX_NO_OFFSET;
            4'ha:    mode_of = (op[3:0] == 4'hd) ? cam_pkg::CAM_BRANCH_OFFSET
                                                 : cam_pkg::CAM_LITERAL_OPERAND;
            4'hb:    mode_of = cam_pkg::CAM_DIRECT;
            4'hc:    mode_of = cam_pkg::CAM_FULL_ADDRESS;
            4'hd:    mode_of = cam_pkg::CAM_INDEX_WORD_OFFSET;
            4'he:    mode_of = cam_pkg::CAM_INDEX_BYTE_OFFSET;
            4'hf:    mode_of = cam_pkg::CAM_INDEX_NO_OFFSET;
            default: mode_of = cam_pkg::CAM_NO_OPERAND; // 4,5,8,9
        endcase
    endfunction : mode_of

    logic [8:0]  low_sum;
    logic [15:0] branch_target;

    // ================================================================
    // address arithmetic; bit modes decode only their direct byte
    always_comb begin
        low_sum       = {1'b0, index} + {1'b0, byte1};
        branch_target = pc + 16'h0002 + {{8{byte1[7]}}, byte1};
        result.mode   = mode_of(opcode);
        result.length = 2'h2;
        result.effective_address = {8'h00, byte1};
        case (result.mode)
            cam_pkg::CAM_NO_OPERAND: begin
                result.length = 2'h1; // opcode only, nothing fetched
                result.effective_address = pc;
            end
            cam_pkg::CAM_LITERAL_OPERAND: begin
                result.effective_address = pc + 16'h0001;
            end
            cam_pkg::CAM_FULL_ADDRESS: begin
                result.length = `CAM_LEN_MAX;
                result.effective_address = {byte1, byte2};
            end
            cam_pkg::CAM_INDEX_NO_OFFSET: begin
                result.length = 2'h1;
                result.effective_address = {8'h00, index};
            end
            cam_pkg::CAM_INDEX_BYTE_OFFSET: begin
                result.effective_address = {7'h00, low_sum}; // carry is high byte
            end
            cam_pkg::CAM_INDEX_WORD_OFFSET: begin
                result.length = `CAM_LEN_MAX;
                result.effective_address = {byte1, byte2} + {8'h00, index};
            end
            cam_pkg::CAM_BRANCH_OFFSET: begin
                // an untaken branch points at the next opcode, never at the offset target
                result.effective_address = taken ? branch_target : pc + 16'h0002;
            end
            cam_pkg::CAM_BIT_TEST_BRANCH: begin
                result.length = `CAM_LEN_MAX;
            end
            default: begin
                result.length = 2'h2; // direct and bit set/clear
            end
        endcase
        // lengths 1..3 bytes
        if ((result.mode == cam_pkg::CAM_BRANCH_OFFSET) && taken) begin
            result.next_pc = branch_target;
        end else begin
            result.next_pc = pc + {14'h0000, result.length};
        end
    end

endmodule : cam_decode

/* cam_defines.svh */
// register offsets, field positions, reset values and counts of the address mode decoder
`ifndef CAM_DEFINES_SVH
`define CAM_DEFINES_SVH

// ====================================================================
// register byte offsets (8-bit local address)
`define CAM_OFF_CTRL    8'h00
`define CAM_OFF_INSN    8'h04
`define CAM_OFF_PC      8'h08
`define CAM_OFF_INDEX   8'h0c
`define CAM_OFF_RESULT  8'h10
`define CAM_OFF_STATUS  8'h14
`define CAM_OFF_FLAGS   8'h18
`define CAM_OFF_ALU     8'h1c

// ====================================================================
// field positions
`define CAM_CTRL_START  0
`define CAM_CTRL_TAKEN  1
`define CAM_FLG_C       0
`define CAM_FLG_Z       1
`define CAM_FLG_N       2
`define CAM_FLG_I       3
`define CAM_FLG_H       4
`define CAM_STAT_LEN_LO 4
`define CAM_STAT_DONE   8

// ====================================================================
// reset values and counts
`define CAM_RST_FLAGS   5'h08
`define CAM_RST_WORD    32'h0000_0000
`define CAM_LEN_MAX     2'h3
`define CAM_RESP_OKAY   2'h0
`define CAM_RESP_DECERR 2'h3

`endif

/* cam_mem_model.sv */
// program memory model that supplies the bytes following an opcode
`timescale 1ns/10ps

// ====================================================================
// read-only byte port, contents a fixed function of the address
module cam_mem_model (
    input  wire logic [15:0] addr, // byte address
    output logic      [7:0]  rd    // byte stored there
);
    // arithmetic fill so neighbours differ and both sign values appear
    assign rd = addr[7:0] + addr[15:8] + 8'hc8;
endmodule : cam_mem_model

/* cam_pkg.sv */
// types shared by the address mode decoder files
package cam_pkg;

    // ================================================================
    // addressing modes
    typedef enum logic [3:0] {
        CAM_NO_OPERAND,
        CAM_LITERAL_OPERAND,
        CAM_DIRECT,
        CAM_FULL_ADDRESS,
        CAM_INDEX_NO_OFFSET,
        CAM_INDEX_BYTE_OFFSET,
        CAM_INDEX_WORD_OFFSET,
        CAM_BRANCH_OFFSET,
        CAM_BIT_SET_CLEAR,
        CAM_BIT_TEST_BRANCH
    } cam_mode_t;

    // decode result carried as one word
    typedef struct packed {
        cam_mode_t   mode;
        logic [1:0]  length;
        logic [15:0] effective_address;
        logic [15:0] next_pc;
    } cam_result_t;

    // flag register contents
    typedef struct packed {
        logic h;
        logic i;
        logic n;
        logic z;
        logic c;
    } cam_flags_t;

endpackage : cam_pkg

/* test_cam_core.sv */
// self-checking bench for the address mode decoder core
`timescale 1ns/10ps

// ====================================================================
// bench top
module test_cam_core;
    localparam logic [31:0] ALL = 32'hffff_ffff;
    logic        clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr, b1, b2, x;
    logic [31:0] wdata, rdata, res, st;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rsp;
    logic [15:0] pc;
    int          errors, n_compared, cyc;

    cam_core uut (.clk(clk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    // operand bytes fetched from pc+1 and pc+2
    cam_mem_model mem1 (.addr(pc + 16'h0001), .rd(b1));
    cam_mem_model mem2 (.addr(pc + 16'h0002), .rd(b2));

    // 40 mhz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ====================================================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // handshakes are judged at the falling edge so no edge race decides them
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok, b_ok;
        b_ok = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_ok) begin
            @(negedge clk);
            aw_ok = awvalid & awready;
            w_ok = wvalid & wready;
            b_ok = bvalid === 1'b1;
            rsp = bresp;
            @(posedge clk);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
            if (b_ok) bready <= 1'b0;
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
        logic ar_ok, r_ok;
        r_ok = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_ok) begin
            @(negedge clk);
            ar_ok = arvalid & arready;
            r_ok = rvalid === 1'b1;
            d = rdata;
            rsp = rresp;
            @(posedge clk);
            if (ar_ok) arvalid <= 1'b0;
            if (r_ok) rready <= 1'b0;
        end
    endtask : axi_rd

    // load one instruction, start it, and fetch result and status
    task automatic run(input logic [7:0] op, input logic tk);
        axi_wr(8'h04, {8'h00, b2, b1, op});
        axi_wr(8'h08, {16'h0000, pc});
        axi_wr(8'h0c, {24'h000000, x});
        axi_wr(8'h00, {30'h0, tk, 1'b1});
        repeat (2) @(posedge clk);
        axi_rd(8'h10, res);
        axi_rd(8'h14, st);
    endtask : run

    task automatic dec(input logic [7:0] op, input logic tk, input cam_pkg::cam_mode_t md,
                       input logic [1:0] ln, input logic [31:0] exp, input logic [31:0] m);
        run(op, tk);
        chk(st & 32'h0000_01ff, {23'h0, 1'b1, 2'h0, ln, md}, "status");
        chk(res & m, exp & m, "result");
    endtask : dec

    task automatic fl(input logic [15:0] ops, input logic [7:0] op, input logic [4:0] f);
        axi_wr(8'h1c, {16'h0000, ops});
        run(op, 1'b0);
        axi_rd(8'h18, res);
        chk(res, {27'h0, f}, "flags");
    endtask : fl

    // ====================================================================
    // scenarios
    task automatic t_reset;
        for (int i = 0; i < 8; i++) begin
            axi_rd(8'(i * 4), res);
            chk(res, (i == 6) ? 32'h0000_0008 : 32'h0000_0000, "reset value");
        end
        $display("test reset values done");
    endtask : t_reset

    // pc near a page end and index 0xf0 so every sum but pc+1 carries
    task automatic t_modes;
        pc = 16'h12fe;
        x = 8'hf0;
        #1;
        dec(8'h9d, 1'b0, cam_pkg::CAM_NO_OPERAND, 2'h1,
            {pc + 16'h1, 16'h0}, 32'hffff_0000);
        dec(8'ha6, 1'b0, cam_pkg::CAM_LITERAL_OPERAND, 2'h2,
            {pc + 16'h2, pc + 16'h1}, ALL);
        dec(8'hb6, 1'b0, cam_pkg::CAM_DIRECT, 2'h2, {pc + 16'h2, 8'h00, b1}, ALL);
        dec(8'hbf, 1'b0, cam_pkg::CAM_DIRECT, 2'h2, {pc + 16'h2, 8'h00, b1}, ALL);
        dec(8'hc6, 1'b0, cam_pkg::CAM_FULL_ADDRESS, 2'h3, {pc + 16'h3, b1, b2}, ALL);
        dec(8'hf6, 1'b0, cam_pkg::CAM_INDEX_NO_OFFSET, 2'h1,
            {pc + 16'h1, 8'h00, x}, ALL);
        dec(8'he6, 1'b0, cam_pkg::CAM_INDEX_BYTE_OFFSET, 2'h2,
            {pc + 16'h2, 7'h00, {1'b0, x} + {1'b0, b1}}, ALL);
        dec(8'hd6, 1'b0, cam_pkg::CAM_INDEX_WORD_OFFSET, 2'h3,
            {pc + 16'h3, {b1, b2} + {8'h00, x}}, ALL);
        dec(8'h10, 1'b0, cam_pkg::CAM_BIT_SET_CLEAR, 2'h2,
            {pc + 16'h2, 8'h00, b1}, ALL);
        dec(8'h01, 1'b0, cam_pkg::CAM_BIT_TEST_BRANCH, 2'h3,
            {16'h0, 8'h00, b1}, 32'hffff);
        $display("test addressing modes done");
    endtask : t_modes

    task automatic t_branch;
        dec(8'h26, 1'b1, cam_pkg::CAM_BRANCH_OFFSET, 2'h2,
            {2{pc + 16'h2 + {{8{b1[7]}}, b1}}}, ALL);
        dec(8'h2f, 1'b0, cam_pkg::CAM_BRANCH_OFFSET, 2'h2, {2{pc + 16'h2}}, ALL);
        // subroutine branch opcode decodes as branch and leaves every flag alone
        dec(8'had, 1'b0, cam_pkg::CAM_BRANCH_OFFSET, 2'h2, {2{pc + 16'h2}}, ALL);
        $display("test branches done");
    endtask : t_branch

    // add, mask and carry opcodes; the unaffected flags must hold
    task automatic t_flags;
        fl(16'h010f, 8'hab, 5'h18);
        fl(16'h01ff, 8'hab, 5'h1b);
        fl(16'h0878, 8'hab, 5'h1c);
        fl(16'h0878, 8'h9d, 5'h1c);
        fl(16'h0878, 8'h9a, 5'h14);
        fl(16'h0878, 8'h99, 5'h15);
        fl(16'h0101, 8'ha9, 5'h00);
        $display("test flags done");
    endtask : t_flags

    task automatic t_unmapped;
        axi_rd(8'h20, res);
        chk({30'h0, rsp}, 32'h3, "read response");
        chk(res, 32'h0, "unmapped data");
        axi_wr(8'h24, ALL);
        chk({30'h0, rsp}, 32'h3, "write response");
        axi_rd(8'h18, res);
        chk(res, 32'h0, "flags kept");
        $display("test unmapped access done");
    endtask : t_unmapped

    task automatic end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    // ====================================================================
    // hang guard; the full run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            end_of_test;
        end
    end

    // main sequence
    initial begin
        {rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, x, pc} = '0;
        wstrb = 4'hf;
        errors = 0;
        n_compared = 0;
        cyc = 0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        t_reset;
        t_modes;
        t_branch;
        t_flags;
        t_unmapped;
        end_of_test;
    end
endmodule : test_cam_core
